// >>> src/scit_pkg.sv
package scit_pkg;

	// ----------------------------------------------------------------
	// Clock and cycle accounting
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 5;
	localparam int CLKS_PER_CYCLE = 1;

	// ----------------------------------------------------------------
	// Instruction lengths in program bytes
	// ----------------------------------------------------------------
	localparam logic [1:0] LEN_1 = 2'h1;
	localparam logic [1:0] LEN_2 = 2'h2;
	localparam logic [1:0] LEN_3 = 2'h3;

	// ----------------------------------------------------------------
	// Execution times in core cycles
	// ----------------------------------------------------------------
	localparam logic [3:0] CYC_1 = 4'h1;
	localparam logic [3:0] CYC_2 = 4'h2;
	localparam logic [3:0] CYC_3 = 4'h3;
	localparam logic [3:0] CYC_4 = 4'h4;
	localparam logic [3:0] CYC_9 = 4'h9;
	localparam logic [3:0] XDATA_BASE_CYC = 4'h4;
	localparam logic [2:0] WAIT_MAX = 3'h7;
	localparam logic [3:0] CYC_MAX = 4'hB;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic RST_FETCH_REQ = 1'b1;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [1:0] RST_LEN = 2'h0;
	localparam logic [3:0] RST_CYC = 4'h0;

	typedef enum logic {SCIT_S_OPC, SCIT_S_RUN} scit_state_t;

endpackage : scit_pkg

// >>> src/scit_dec.sv
`timescale 1ns/100ps
module scit_dec
	import scit_pkg::*;
(
	input wire logic [7:0] opcode,
	output logic [1:0] len,
	output logic [3:0] cyc,
	output logic ext
);

	// ----------------------------------------------------------------
	// Opcode class table: {external data move, bytes, cycles}
	// ----------------------------------------------------------------
	function automatic logic [6:0] scit_class(input logic [7:0] op);
		logic [6:0] r;
		r = {1'b0, LEN_1, CYC_1};
		casez (op)
			// Accumulator arithmetic and logic on a working register. [RULE1]
			8'b0010_1???, 8'b0011_1???, 8'b1001_1???,
			8'b0100_1???, 8'b0101_1???, 8'b0110_1???: r = {1'b0, LEN_1, CYC_1};
			// Same operations through a pointer register. [RULE2]
			8'b0010_011?, 8'b0011_011?, 8'b1001_011?,
			8'b0100_011?, 8'b0101_011?, 8'b0110_011?: r = {1'b0, LEN_1, CYC_2};
			// Direct or immediate operand, logic into direct. [RULE3] [RULE4]
			8'h24, 8'h25, 8'h34, 8'h35, 8'h94, 8'h95,
			8'h44, 8'h45, 8'h54, 8'h55, 8'h64, 8'h65,
			8'h42, 8'h52, 8'h62: r = {1'b0, LEN_2, CYC_2};
			8'h43, 8'h53, 8'h63: r = {1'b0, LEN_3, CYC_3};
			// Increment and decrement.
			8'h04, 8'h14, 8'b0000_1???, 8'b0001_1???: r = {1'b0, LEN_1, CYC_1};
			8'b0000_011?, 8'b0001_011?: r = {1'b0, LEN_1, CYC_2};
			8'h05, 8'h15: r = {1'b0, LEN_2, CYC_2};
			8'hA3: r = {1'b0, LEN_1, CYC_3};
			8'h90: r = {1'b0, LEN_3, CYC_3}; // [RULE5]
			8'hA4: r = {1'b0, LEN_1, CYC_4};
			8'h84: r = {1'b0, LEN_1, CYC_9};
			8'hD4: r = {1'b0, LEN_1, CYC_2};
			// Accumulator rotate, swap, clear and complement. [RULE6]
			8'h03, 8'h13, 8'h23, 8'h33, 8'hC4, 8'hE4, 8'hF4: r = {1'b0, LEN_1, CYC_1};
			// Moves and exchanges with a working register. [RULE7]
			8'b1110_1???, 8'b1111_1???, 8'b1100_1???: r = {1'b0, LEN_1, CYC_1};
			// Indirect internal memory moves and exchanges. [RULE8] [RULE13]
			8'hE6, 8'hE7, 8'hF6, 8'hF7, 8'hC6, 8'hC7, 8'hD6, 8'hD7: r = {1'b0, LEN_1, CYC_2};
			8'h74, 8'h76, 8'h77, 8'b0111_1???, 8'h86, 8'h87, 8'b1000_1???,
			8'hA6, 8'hA7, 8'b1010_1???, 8'hE5, 8'hF5, 8'hC5: r = {1'b0, LEN_2, CYC_2};
			8'h75, 8'h85: r = {1'b0, LEN_3, CYC_3}; // [RULE9]
			8'h83, 8'h93: r = {1'b0, LEN_1, CYC_4}; // [RULE10]
			// External data moves; wait states are added by the sequencer.
			8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3: r = {1'b1, LEN_1, XDATA_BASE_CYC};
			8'hC0, 8'hD0: r = {1'b0, LEN_2, CYC_2}; // [RULE12]
			// Boolean operations. [RULE14]
			8'hC3, 8'hD3, 8'hB3: r = {1'b0, LEN_1, CYC_1};
			8'hC2, 8'hD2, 8'hB2, 8'h82, 8'hB0, 8'h72, 8'hA0, 8'hA2, 8'h92:
				r = {1'b0, LEN_2, CYC_2};
			// Branching.
			8'h73: r = {1'b0, LEN_1, CYC_3}; // [RULE15]
			8'h22, 8'h32: r = {1'b0, LEN_1, CYC_4};
			8'b???1_0001, 8'b???0_0001: r = {1'b0, LEN_2, CYC_3}; // [RULE16]
			8'h80, 8'h40, 8'h50, 8'h60, 8'h70, 8'b1101_1???: r = {1'b0, LEN_2, CYC_3};
			8'h02, 8'h12, 8'h20, 8'h30, 8'h10, 8'hB4, 8'hB5, 8'hB6, 8'hB7,
			8'b1011_1???, 8'hD5: r = {1'b0, LEN_3, CYC_4};
			default: r = {1'b0, LEN_1, CYC_1};
		endcase
		return r;
	endfunction : scit_class

	wire logic [6:0] cls;

	assign cls = scit_class(opcode);
	assign ext = cls[6];
	assign len = cls[5:4];
	assign cyc = cls[3:0];

endmodule : scit_dec

// >>> src/scit_core.sv
// What this block does
// (RULE1) Accumulator operations on a working register: one byte, one cycle.
// (RULE2) Accumulator operations through a pointer register: one byte, two cycles.
// (RULE3) Accumulator operations, direct or immediate operand: two bytes, two cycles.
// (RULE4) AND, OR, XOR of immediate into direct byte: three bytes, three cycles.
// (RULE5) Load data pointer: three bytes, three cycles; increment: one byte, three.
// (RULE6) Rotate, swap, clear, complement of accumulator: one byte, one cycle.
// (RULE7) Accumulator and working register move or exchange: one byte, one cycle.
// (RULE8) Accumulator and indirect internal memory moves: one byte, two cycles.
// (RULE9) Direct to direct or immediate to direct: three bytes, three cycles.
// (RULE10) Code byte read via accumulator plus pointer: one byte, four cycles.
// (RULE11) External data transfers by either pointer: one byte, four cycles.
// (RULE12) Stack push and pop of a direct byte: two bytes, two cycles.
// (RULE13) Low nibble exchange with indirect memory: one byte, two cycles.
// (RULE14) Direct bit clear, set, complement, carry logic, moves: two bytes, two.
// (RULE15) Jump to accumulator plus data pointer: one byte, three cycles.
// (RULE16) Short absolute call and jump: two bytes, three cycles.
// (RULE17) Every counted cycle is exactly one core clock period.
// (RULE18) External data transfers take four cycles plus the wait count.
// (RULE19) The external wait count ranges from zero to seven.
// (RULE20) All bytes fetched before completion; next opcode held until done.
`timescale 1ns/100ps
module scit_core
	import scit_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic code_valid,
	input wire logic [7:0] code_byte,
	input wire logic [2:0] external_wait_count,
	output logic fetch_req,
	output logic insn_done,
	output logic insn_busy,
	output logic [7:0] insn_opcode,
	output logic [7:0] insn_operand1,
	output logic [7:0] insn_operand2,
	output logic [1:0] insn_len,
	output logic [3:0] insn_cycles,
	output logic insn_ext
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	scit_state_t state_r;
	scit_state_t state_nxt;
	logic fetch_req_r;
	logic insn_done_r;
	logic insn_busy_r;
	logic [7:0] opc_r;
	logic [7:0] op1_r;
	logic [7:0] op2_r;
	logic [1:0] len_r;
	logic [1:0] bytes_r;
	logic [3:0] total_r;
	logic [3:0] cyc_r;
	logic ext_r;
	logic [7:0] insn_opcode_r;
	logic [7:0] insn_operand1_r;
	logic [7:0] insn_operand2_r;
	logic [1:0] insn_len_r;
	logic [3:0] insn_cycles_r;
	logic insn_ext_r;

	// ----------------------------------------------------------------
	// Opcode decode
	// ----------------------------------------------------------------
	wire logic [1:0] dec_len;
	wire logic [3:0] dec_cyc;
	wire logic dec_ext;

	scit_dec u_dec (
		.opcode(code_byte),
		.len(dec_len),
		.cyc(dec_cyc),
		.ext(dec_ext)
	);

	// ----------------------------------------------------------------
	// Sequencing
	// ----------------------------------------------------------------
	wire logic take;
	wire logic opc_take;
	wire logic byte_take;
	wire logic running;
	wire logic [3:0] wait_cyc;
	wire logic [3:0] dec_total;
	wire logic [1:0] len_cur;
	wire logic [3:0] tot_cur;
	wire logic [7:0] opc_cur;
	wire logic ext_cur;
	wire logic [1:0] bytes_nxt;
	wire logic [3:0] cyc_nxt;
	wire logic fin;
	wire logic fetch_req_nxt;
	wire logic [7:0] op1_nxt;
	wire logic [7:0] op2_nxt;

	assign take = fetch_req_r & code_valid;
	assign running = (state_r == SCIT_S_RUN);
	assign opc_take = take & ~running;
	assign byte_take = take & running;
	// Only three bits of wait count exist, so the limit of seven is structural.
	assign wait_cyc = {1'b0, external_wait_count}; // [RULE19]
	assign dec_total = dec_ext ? 4'(XDATA_BASE_CYC + wait_cyc) : dec_cyc; // [RULE18]
	assign len_cur = opc_take ? dec_len : len_r;
	assign tot_cur = opc_take ? dec_total : total_r;
	assign opc_cur = opc_take ? code_byte : opc_r;
	assign ext_cur = opc_take ? dec_ext : ext_r;
	assign bytes_nxt = opc_take ? LEN_1 : 2'(bytes_r + {1'b0, byte_take});
	// One core clock advances the cycle count by exactly one.
	assign cyc_nxt = opc_take ? CYC_1 : 4'(cyc_r + CYC_1); // [RULE17]
	// Completion waits for both the cycle budget and the last operand byte.
	assign fin = (opc_take | running) & (cyc_nxt >= tot_cur)
		& (bytes_nxt == len_cur); // [RULE20]
	assign state_nxt = fin ? SCIT_S_OPC : (opc_take ? SCIT_S_RUN : state_r);
	// Fetch stops once all bytes are in, holding off the next opcode.
	assign fetch_req_nxt = (state_nxt == SCIT_S_OPC)
		| (bytes_nxt < len_cur); // [RULE20]
	assign op1_nxt = opc_take ? RST_BYTE
		: ((byte_take && bytes_r == LEN_1) ? code_byte : op1_r);
	assign op2_nxt = opc_take ? RST_BYTE
		: ((byte_take && bytes_r == LEN_2) ? code_byte : op2_r);

	// ----------------------------------------------------------------
	// Sequencer registers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_r <= SCIT_S_OPC;
			fetch_req_r <= RST_FETCH_REQ;
			opc_r <= RST_BYTE;
			op1_r <= RST_BYTE;
			op2_r <= RST_BYTE;
			len_r <= RST_LEN;
			bytes_r <= RST_LEN;
			total_r <= RST_CYC;
			cyc_r <= RST_CYC;
			ext_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			fetch_req_r <= fetch_req_nxt;
			opc_r <= opc_cur;
			op1_r <= op1_nxt;
			op2_r <= op2_nxt;
			len_r <= len_cur;
			bytes_r <= bytes_nxt;
			total_r <= tot_cur; // [RULE1] [RULE10] [RULE11] [RULE16]
			cyc_r <= cyc_nxt;
			ext_r <= ext_cur;
		end
	end

	// ----------------------------------------------------------------
	// Completion report
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			insn_done_r <= 1'b0;
			insn_busy_r <= 1'b0;
			insn_opcode_r <= RST_BYTE;
			insn_operand1_r <= RST_BYTE;
			insn_operand2_r <= RST_BYTE;
			insn_len_r <= RST_LEN;
			insn_cycles_r <= RST_CYC;
			insn_ext_r <= 1'b0;
		end else begin
			insn_done_r <= fin;
			insn_busy_r <= (state_nxt == SCIT_S_RUN);
			if (fin) begin
				insn_opcode_r <= opc_cur;
				insn_operand1_r <= op1_nxt;
				insn_operand2_r <= op2_nxt;
				insn_len_r <= len_cur;
				insn_cycles_r <= tot_cur;
				insn_ext_r <= ext_cur;
			end
		end
	end

	assign fetch_req = fetch_req_r;
	assign insn_done = insn_done_r;
	assign insn_busy = insn_busy_r;
	assign insn_opcode = insn_opcode_r;
	assign insn_operand1 = insn_operand1_r;
	assign insn_operand2 = insn_operand2_r;
	assign insn_len = insn_len_r;
	assign insn_cycles = insn_cycles_r;
	assign insn_ext = insn_ext_r;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	// Clocks from opcode acceptance, and whether any operand byte stalled.
	logic [3:0] chk_elapsed_r;
	logic chk_stall_r;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			chk_elapsed_r <= RST_CYC;
			chk_stall_r <= 1'b0;
		end else begin
			chk_elapsed_r <= cyc_nxt;
			chk_stall_r <= opc_take ? 1'b0
				: (chk_stall_r | (fetch_req_r & ~code_valid));
		end
	end

	a_wreg_alu_one: assert property ( // [RULE1]
		@(posedge ref_clk) disable iff (rst)
		opc_take && (code_byte[7:3] == 5'b00101 || code_byte[7:3] == 5'b10011)
		|=> insn_done && insn_len == LEN_1 && insn_cycles == CYC_1)
		else $error("working register arithmetic not one byte one cycle");

	a_ptr_alu_two: assert property ( // [RULE2]
		@(posedge ref_clk) disable iff (rst)
		opc_take && code_byte[7:1] == 7'b0101_011
		|=> !insn_done ##1 insn_done && insn_cycles == CYC_2)
		else $error("indirect logic operation not two cycles");

	a_imm_alu_two: assert property ( // [RULE3]
		@(posedge ref_clk) disable iff (rst)
		insn_done && (insn_opcode == 8'h24 || insn_opcode == 8'h65)
		|-> insn_len == LEN_2 && insn_cycles == CYC_2)
		else $error("direct or immediate operation not two bytes two cycles");

	a_imm_logic_three: assert property ( // [RULE4]
		@(posedge ref_clk) disable iff (rst)
		insn_done && (insn_opcode == 8'h43 || insn_opcode == 8'h53
		|| insn_opcode == 8'h63)
		|-> insn_len == LEN_3 && insn_cycles == CYC_3)
		else $error("immediate into direct byte not three bytes three cycles");

	a_dptr_inc_three: assert property ( // [RULE5]
		@(posedge ref_clk) disable iff (rst)
		opc_take && code_byte == 8'hA3
		|=> !insn_done [*2] ##1 insn_done && insn_len == LEN_1)
		else $error("data pointer increment not three cycles");

	a_acc_rot_one: assert property ( // [RULE6]
		@(posedge ref_clk) disable iff (rst)
		opc_take && (code_byte == 8'hC4 || code_byte == 8'h33)
		|=> insn_done && insn_cycles == CYC_1 && fetch_req)
		else $error("accumulator rotate or swap not single cycle");

	a_xch_wreg_one: assert property ( // [RULE7]
		@(posedge ref_clk) disable iff (rst)
		opc_take && code_byte[7:3] == 5'b11001
		|=> insn_done && insn_opcode == $past(code_byte))
		else $error("register exchange not single cycle");

	a_ind_mov_two: assert property ( // [RULE8]
		@(posedge ref_clk) disable iff (rst)
		insn_done && insn_opcode[7:1] == 7'b1111_011
		|-> insn_cycles == CYC_2 && insn_len == LEN_1)
		else $error("indirect store not one byte two cycles");

	a_dir_dir_three: assert property ( // [RULE9]
		@(posedge ref_clk) disable iff (rst)
		insn_done && (insn_opcode == 8'h85 || insn_opcode == 8'h75)
		|-> insn_len == LEN_3 && insn_cycles == CYC_3)
		else $error("direct copy not three bytes three cycles");

	a_code_move_four: assert property ( // [RULE10]
		@(posedge ref_clk) disable iff (rst)
		opc_take && (code_byte == 8'h83 || code_byte == 8'h93)
		|=> !insn_done [*3] ##1 insn_done && insn_cycles == CYC_4)
		else $error("code byte move not four cycles");

	a_xdata_wait_time: assert property ( // [RULE11] [RULE18]
		@(posedge ref_clk) disable iff (rst)
		opc_take && code_byte == 8'hE0
		|=> insn_busy ##1 insn_busy ##1 insn_busy
		##0 (total_r == 4'(XDATA_BASE_CYC
		+ {1'b0, $past(external_wait_count, 3)})))
		else $error("external transfer time not four plus wait count");

	a_stack_two: assert property ( // [RULE12]
		@(posedge ref_clk) disable iff (rst)
		insn_done && (insn_opcode == 8'hC0 || insn_opcode == 8'hD0)
		|-> insn_len == LEN_2 && insn_cycles == CYC_2)
		else $error("push or pop not two bytes two cycles");

	a_nibble_xch_two: assert property ( // [RULE13]
		@(posedge ref_clk) disable iff (rst)
		opc_take && code_byte[7:1] == 7'b1101_011
		|=> !insn_done ##1 insn_done && insn_len == LEN_1)
		else $error("low nibble exchange not two cycles");

	a_bit_op_two: assert property ( // [RULE14]
		@(posedge ref_clk) disable iff (rst)
		insn_done && (insn_opcode == 8'hB2 || insn_opcode == 8'hB0
		|| insn_opcode == 8'h92)
		|-> insn_len == LEN_2 && insn_cycles == CYC_2)
		else $error("direct bit operation not two bytes two cycles");

	a_jmp_ind_three: assert property ( // [RULE15]
		@(posedge ref_clk) disable iff (rst)
		opc_take && code_byte == 8'h73
		|=> !insn_done [*2] ##1 insn_done)
		else $error("indirect jump not three cycles");

	a_abs_call_three: assert property ( // [RULE16]
		@(posedge ref_clk) disable iff (rst)
		insn_done && insn_opcode[4:0] == 5'b10001
		|-> insn_len == LEN_2 && insn_cycles == CYC_3)
		else $error("absolute call not two bytes three cycles");

	a_cycle_one_clock: assert property ( // [RULE17]
		@(posedge ref_clk) disable iff (rst)
		insn_done && !chk_stall_r |-> chk_elapsed_r == insn_cycles)
		else $error("cycle count differs from clocks elapsed");

	a_wait_range: assert property ( // [RULE19]
		@(posedge ref_clk) disable iff (rst)
		insn_done |-> insn_cycles <= CYC_MAX)
		else $error("instruction time beyond eleven cycles");

	a_fetch_hold: assert property ( // [RULE20]
		@(posedge ref_clk) disable iff (rst)
		running && bytes_r == len_r |-> !fetch_req)
		else $error("fetch requested after all bytes taken");

	a_all_bytes: assert property ( // [RULE20]
		@(posedge ref_clk) disable iff (rst)
		insn_done |-> $past(bytes_nxt) == insn_len)
		else $error("instruction finished before all bytes fetched");

endmodule : scit_core

// >>> tb/testbench.sv
`timescale 1ns/100ps
module testbench
	import scit_pkg::*;
;
	// ----------------------------------------------------------------
	// Stimulus table and expectation queue
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] op;
		logic [1:0] len;
		logic [3:0] cyc;
		logic ext;
	} scit_tb_row_t;
	typedef struct {
		logic [7:0] op;
		logic [7:0] o1;
		logic [7:0] o2;
		logic [1:0] len;
		logic [3:0] cyc;
		logic ext;
		int at;
	} scit_tb_exp_t;
	localparam int NROW = 49;
	localparam int LIMIT = 20000;
	localparam logic [3:0] XB = XDATA_BASE_CYC;
	scit_tb_row_t tbl [0:NROW-1] = '{
		'{8'h3B, LEN_1, CYC_1, 1'b0}, '{8'h9A, LEN_1, CYC_1, 1'b0},
		'{8'h26, LEN_1, CYC_2, 1'b0}, '{8'h97, LEN_1, CYC_2, 1'b0},
		'{8'h95, LEN_2, CYC_2, 1'b0}, '{8'h44, LEN_2, CYC_2, 1'b0},
		'{8'h25, LEN_2, CYC_2, 1'b0}, '{8'h53, LEN_3, CYC_3, 1'b0},
		'{8'h43, LEN_3, CYC_3, 1'b0}, '{8'h63, LEN_3, CYC_3, 1'b0},
		'{8'h90, LEN_3, CYC_3, 1'b0}, '{8'hA3, LEN_1, CYC_3, 1'b0},
		'{8'h23, LEN_1, CYC_1, 1'b0}, '{8'h13, LEN_1, CYC_1, 1'b0},
		'{8'hC4, LEN_1, CYC_1, 1'b0}, '{8'hE4, LEN_1, CYC_1, 1'b0},
		'{8'hF4, LEN_1, CYC_1, 1'b0}, '{8'h03, LEN_1, CYC_1, 1'b0},
		'{8'h33, LEN_1, CYC_1, 1'b0}, '{8'hCD, LEN_1, CYC_1, 1'b0},
		'{8'hFA, LEN_1, CYC_1, 1'b0}, '{8'hEF, LEN_1, CYC_1, 1'b0},
		'{8'hE7, LEN_1, CYC_2, 1'b0}, '{8'hF6, LEN_1, CYC_2, 1'b0},
		'{8'h85, LEN_3, CYC_3, 1'b0}, '{8'h75, LEN_3, CYC_3, 1'b0},
		'{8'h93, LEN_1, CYC_4, 1'b0}, '{8'h83, LEN_1, CYC_4, 1'b0},
		'{8'hE2, LEN_1, XB, 1'b1}, '{8'hE0, LEN_1, XB, 1'b1},
		'{8'hF3, LEN_1, XB, 1'b1}, '{8'hF0, LEN_1, XB, 1'b1},
		'{8'hC0, LEN_2, CYC_2, 1'b0}, '{8'hD0, LEN_2, CYC_2, 1'b0},
		'{8'hD7, LEN_1, CYC_2, 1'b0}, '{8'hC2, LEN_2, CYC_2, 1'b0},
		'{8'hD2, LEN_2, CYC_2, 1'b0}, '{8'hB2, LEN_2, CYC_2, 1'b0},
		'{8'h82, LEN_2, CYC_2, 1'b0}, '{8'hB0, LEN_2, CYC_2, 1'b0},
		'{8'h72, LEN_2, CYC_2, 1'b0}, '{8'hA0, LEN_2, CYC_2, 1'b0},
		'{8'hA2, LEN_2, CYC_2, 1'b0}, '{8'h92, LEN_2, CYC_2, 1'b0},
		'{8'h73, LEN_1, CYC_3, 1'b0}, '{8'h11, LEN_2, CYC_3, 1'b0},
		'{8'h01, LEN_2, CYC_3, 1'b0}, '{8'hF1, LEN_2, CYC_3, 1'b0},
		'{8'hE1, LEN_2, CYC_3, 1'b0}
	};
	scit_tb_exp_t exp_q [$];
	scit_tb_exp_t got;
	logic ref_clk, rst, code_valid;
	logic [7:0] code_byte;
	logic [2:0] external_wait_count;
	logic fetch_req, insn_done, insn_busy, insn_ext;
	logic [7:0] insn_opcode, insn_operand1, insn_operand2;
	logic [1:0] insn_len;
	logic [3:0] insn_cycles;
	int seed = 9;
	int cyc_count = 0;
	int num_errors = 0;
	int check_count = 0;

	scit_core i_scit_core (
		.ref_clk(ref_clk), .rst(rst), .code_valid(code_valid),
		.code_byte(code_byte), .external_wait_count(external_wait_count),
		.fetch_req(fetch_req), .insn_done(insn_done), .insn_busy(insn_busy),
		.insn_opcode(insn_opcode), .insn_operand1(insn_operand1),
		.insn_operand2(insn_operand2), .insn_len(insn_len),
		.insn_cycles(insn_cycles), .insn_ext(insn_ext)
	);

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] want,
		input string what);
		check_count++;
		if (seen !== want) begin
			num_errors++;
			$display("BAD %0t %s seen %0h want %0h", $time, what, seen, want);
		end
	endtask : check

	task automatic results();
		check(32'(exp_q.size()), 32'h0, "pending results");
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : results

	// Called at a falling edge; returns at a falling edge with the
	// strobe still up, so a following call never drives it twice.
	task automatic send_insn(input int idx, input int stall,
		input logic [2:0] w);
		scit_tb_exp_t x;
		logic [7:0] b [3];
		int n;
		b[0] = tbl[idx].op;
		b[1] = 8'($random(seed));
		b[2] = 8'($random(seed));
		x.op = b[0];
		x.len = tbl[idx].len;
		x.o1 = (x.len > LEN_1) ? b[1] : 8'h00;
		x.o2 = (x.len > LEN_2) ? b[2] : 8'h00;
		x.ext = tbl[idx].ext;
		x.cyc = x.ext ? XDATA_BASE_CYC + 4'(w) : tbl[idx].cyc;
		for (int i = 0; i < int'(x.len); i++) begin
			if (i > 0) begin
				repeat (stall) begin
					code_valid = 1'b0;
					code_byte = 8'($random(seed));
					@(negedge ref_clk);
				end
			end
			code_valid = 1'b1;
			code_byte = b[i];
			if (i == 0) external_wait_count = w;
			n = 0;
			while (fetch_req !== 1'b1 && n < 40) begin
				@(negedge ref_clk);
				n++;
			end
			// Done shows in the cycle after the edge that finishes.
			if (i == 0) x.at = cyc_count + int'(x.cyc);
			else if (cyc_count + 1 > x.at) x.at = cyc_count + 1;
			@(negedge ref_clk);
		end
		exp_q.push_back(x);
	endtask : send_insn

	// ----------------------------------------------------------------
	// Clock, timeout and result monitor
	// ----------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) begin
		cyc_count <= cyc_count + 1;
		if (cyc_count == LIMIT) begin
			num_errors++;
			results();
		end
	end

	always @(negedge ref_clk) begin
		if (rst === 1'b0 && insn_done === 1'b1) begin
			if (exp_q.size() == 0) begin
				check(32'(insn_opcode), 32'h100, "unexpected done");
			end else begin
				got = exp_q.pop_front();
				check(32'(insn_opcode), 32'(got.op), "opcode");
				check(32'(insn_operand1), 32'(got.o1), "operand1");
				check(32'(insn_operand2), 32'(got.o2), "operand2");
				check(32'(insn_len), 32'(got.len), "length");
				check(32'(insn_cycles), 32'(got.cyc), "cycles");
				check(32'(insn_ext), 32'(got.ext), "ext flag");
				check(32'(cyc_count), 32'(got.at), "done time");
				check(32'(insn_busy), 32'h0, "busy at done");
				check(32'(fetch_req), 32'h1, "fetch at done");
			end
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	task automatic idle_checks(input string what);
		check(32'(fetch_req), 32'(RST_FETCH_REQ), what);
		check(32'(insn_done), 32'h0, what);
		check(32'(insn_busy), 32'h0, what);
		check(32'(insn_opcode), 32'(RST_BYTE), what);
		check(32'(insn_cycles), 32'(RST_CYC), what);
		check(32'(insn_len), 32'(RST_LEN), what);
	endtask : idle_checks

	initial begin
		rst = 1'b1;
		code_valid = 1'b0;
		code_byte = 8'h00;
		external_wait_count = 3'h0;
		repeat (8) @(negedge ref_clk);
		idle_checks("reset state");
		rst = 1'b0;
		@(negedge ref_clk);
		// Every table row back to back, then external moves at every wait.
		for (int i = 0; i < NROW; i++) send_insn(i, 0, 3'($random(seed)));
		for (int i = 0; i < NROW; i++) begin
			if (tbl[i].ext) begin
				for (int w = 0; w <= int'(WAIT_MAX); w++) send_insn(i, 0, 3'(w));
			end
		end
		// Random mix with operand bytes arriving late.
		for (int k = 0; k < 200; k++) begin
			send_insn({$random(seed)} % NROW, {$random(seed)} % 3,
				3'($random(seed)));
		end
		code_valid = 1'b0;
		repeat (16) @(negedge ref_clk);
		// Reset in mid-instruction must drop it without a completion.
		code_valid = 1'b1;
		code_byte = 8'h75;
		@(negedge ref_clk);
		check(32'(insn_busy), 32'h1, "busy mid insn");
		code_valid = 1'b0;
		rst = 1'b1;
		@(negedge ref_clk);
		idle_checks("mid reset");
		rst = 1'b0;
		@(negedge ref_clk);
		send_insn(25, 1, 3'h0);
		send_insn(28, 0, WAIT_MAX);
		code_valid = 1'b0;
		repeat (20) @(negedge ref_clk);
		results();
	end

endmodule : testbench
